// [rtl/ssc_clock_ctrl.sv]
`include "ssc_defines.svh"

module ssc_clock_ctrl #(
    parameter logic [14:0] SLOW_CAL_CYCLES = 15'(`SSC_SLOW_CAL_CYCLES)
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_we,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    // Loose control bits from the sleep register
    input  wire logic       pd_wr_en,
    input  wire logic       pd_wr_val,
    input  wire logic       caldis_wr_en,
    input  wire logic       caldis_wr_val,
    output logic            unused_source_powerdown,
    output logic            slow_rc_cal_disable,
    output logic            xtal_stable_flag,
    output logic            hfrc_stable_flag,
    // Oscillator analog side
    input  wire logic       xtal_ready,
    input  wire logic       hfrc_ready,
    output logic            xtal_pwr_en,
    output logic            hfrc_pwr_en,
    output logic            hfrc_cal_en,
    output logic            slow_xtal_en,
    output logic            slow_rc_en,
    output logic            slow_rc_cal_active,
    // System clock mux
    output logic            sys_clk_sel,
    output logic            sys_clk_gate_en,
    output logic            sys_clk_speed_flag,
    // Slow clock consumers
    input  wire logic       slow_clk_in,
    output logic            mac_sleep_strobe,
    // Power mode handshake
    input  wire logic       lp_req,
    input  wire logic [1:0] lp_mode,
    input  wire logic       deep_wake,
    output logic            lp_grant
);
    ssc_pkg::ssc_ctl_s q;
    ssc_pkg::ssc_ctl_s d;
    logic              cur_src;
    logic              gate_en;
    logic              sw_busy;
    logic              ctrl_hit;
    logic              cal_start;
    logic              cal_done;
    logic [7:0]        ctrl_val;

    // ==============================================================
    // Glitch-free source switch
    ssc_clk_switch u_switch (
        .clock       (clock),
        .nrst        (nrst),
        .target_sel  (q.osc_tgt),
        .xtal_ok     (q.xtal_stb),
        .hfrc_ok     (q.hfrc_stb),
        .cur_sel     (cur_src),
        .clk_gate_en (gate_en),
        .busy        (sw_busy)
    );

    // ==============================================================
    // Register decode
    always_comb begin
        if (sfr_addr == `SSC_CLK_CTRL_ADDR) begin
            ctrl_hit = 1'b1;
        end else begin
            ctrl_hit = 1'b0;
        end
    end

    // Reserved bits 2:1 read zero; speed flag is the applied source
    assign ctrl_val = {q.slow_sel, q.osc_tgt, q.tick, 2'h0, cur_src};

    // Slow calibration only from a stable crystal, in active mode
    assign cal_start = !q.cal_busy && cur_src == `SSC_SRC_XTAL && q.xtal_stb
                       && !lp_req && !q.caldis_eff && q.slow_sel;
    assign cal_done  = q.cal_busy && q.cal_cnt == SLOW_CAL_CYCLES - 15'h1;

    // ==============================================================
    // Next state
    always_comb begin
        d = q;

        // Software writes
        if (sfr_we && ctrl_hit) begin
            d.slow_sel = sfr_wdata[`SSC_BIT_SLOW_SEL];
            d.osc_tgt = sfr_wdata[`SSC_BIT_OSC];
            d.tick    = sfr_wdata[`SSC_TICK_MSB:`SSC_TICK_LSB];
        end
        if (caldis_wr_en) begin
            d.caldis = caldis_wr_val;
        end
        // A set only counts once the fast RC drives the system
        if (!d.caldis) begin
            d.caldis_eff = 1'b0;
        end else if (cur_src == `SSC_SRC_RC) begin
            d.caldis_eff = 1'b1;
        end

        // Power-down control, deferred across a calibration
        if (pd_wr_en && (q.cal_busy || q.pd_pend)) begin
            d.pd_pend     = 1'b1;
            d.pd_pend_val = pd_wr_val;
        end else if (pd_wr_en) begin
            d.pd = pd_wr_val;
        end
        if (q.pd_pend && !q.cal_busy && !pd_wr_en) begin
            d.pd      = q.pd_pend_val;
            d.pd_pend = 1'b0;
        end

        // Slow RC calibration; disable never aborts a running one
        if (cal_start) begin
            d.cal_busy = 1'b1;
            d.cal_cnt  = 15'h0;
        end else if (cal_done) begin
            d.cal_busy = 1'b0;
            d.cal_cnt  = 15'h0;
        end else if (q.cal_busy) begin
            d.cal_cnt = q.cal_cnt + 15'h1;
        end

        // Fast oscillator power: old source kept until swap completes
        d.xtal_pwr = !q.pd || q.osc_tgt == `SSC_SRC_XTAL
                     || cur_src == `SSC_SRC_XTAL;
        d.hfrc_pwr = !q.pd || q.osc_tgt == `SSC_SRC_RC
                     || cur_src == `SSC_SRC_RC;
        d.xtal_stb = q.xtal_pwr && xtal_ready;
        d.hfrc_stb = q.hfrc_pwr && hfrc_ready;

        // Fast RC trimmed only while crystal runs the system
        d.hfrc_cal = cur_src == `SSC_SRC_XTAL && !sw_busy
                     && q.hfrc_pwr && q.hfrc_stb;

        // Exactly one slow oscillator runs
        d.slow_xtal_en = !d.slow_sel;
        d.slow_rc_en   = d.slow_sel;

        // Slow clock edge marks the MAC timer sleep computation
        d.slow_in    = slow_clk_in;
        d.mac_strobe = slow_clk_in && !q.slow_in;

        // Light and deep sleep wait for calibration to end
        if (!lp_req) begin
            d.lp_grant = 1'b0;
        end else if (!q.cal_busy && !cal_start) begin
            d.lp_grant = 1'b1;
        end

        // Return from the deepest modes loses these two bits only
        if (deep_wake) begin
            d.slow_sel     = `SSC_SLOW_SEL_RESET;
            d.slow_xtal_en = 1'b0;
            d.slow_rc_en   = 1'b1;
            d.caldis       = 1'b0;
            d.caldis_eff   = 1'b0;
        end

        // Registered read data, unmapped reads return zero
        if (ctrl_hit) begin
            d.rdata = ctrl_val;
        end else begin
            d.rdata = 8'h00;
        end
    end

    // ==============================================================
    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q.slow_sel     <= `SSC_SLOW_SEL_RESET;
            q.osc_tgt      <= `SSC_SRC_RC;
            q.tick         <= `SSC_TICK_RESET;
            q.pd           <= 1'b1;
            q.pd_pend      <= 1'b0;
            q.pd_pend_val  <= 1'b0;
            q.caldis       <= 1'b0;
            q.caldis_eff   <= 1'b0;
            q.cal_busy     <= 1'b0;
            q.cal_cnt      <= 15'h0;
            q.slow_in      <= 1'b0;
            q.mac_strobe   <= 1'b0;
            q.lp_grant     <= 1'b0;
            q.xtal_pwr     <= 1'b0;
            q.hfrc_pwr     <= 1'b1;
            q.xtal_stb     <= 1'b0;
            q.hfrc_stb     <= 1'b0;
            q.hfrc_cal     <= 1'b0;
            q.slow_xtal_en <= 1'b0;
            q.slow_rc_en   <= 1'b1;
            q.rdata        <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ==============================================================
    // Outputs
    assign sfr_rdata               = q.rdata;
    assign unused_source_powerdown = q.pd;
    assign slow_rc_cal_disable     = q.caldis;
    assign xtal_stable_flag        = q.xtal_stb;
    assign hfrc_stable_flag        = q.hfrc_stb;
    assign xtal_pwr_en             = q.xtal_pwr;
    assign hfrc_pwr_en             = q.hfrc_pwr;
    assign hfrc_cal_en             = q.hfrc_cal;
    assign slow_xtal_en            = q.slow_xtal_en;
    assign slow_rc_en              = q.slow_rc_en;
    assign slow_rc_cal_active      = q.cal_busy;
    assign sys_clk_sel             = cur_src;
    assign sys_clk_gate_en         = gate_en;
    assign sys_clk_speed_flag      = cur_src;
    assign mac_sleep_strobe        = q.mac_strobe;
    assign lp_grant                = q.lp_grant;
endmodule : ssc_clock_ctrl

// [rtl/ssc_defines.svh]
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ==============================================================
// Register map
`define SSC_CLK_CTRL_ADDR    8'hC6
`define SSC_CLK_CTRL_RESET   8'hC9
`define SSC_SLOW_SEL_RESET   1'b1
`define SSC_BIT_SLOW_SEL     7
`define SSC_BIT_OSC          6
`define SSC_TICK_MSB         5
`define SSC_TICK_LSB         3
`define SSC_BIT_SPEED        0
`define SSC_TICK_RESET       3'h1
`define SSC_SRC_XTAL         1'b0
`define SSC_SRC_RC           1'b1

// ==============================================================
// Timing
`define SSC_CLK_PERIOD_NS    100
`define SSC_SLOW_CAL_TIME_US 2000
`define SSC_SLOW_CAL_CYCLES  ((`SSC_SLOW_CAL_TIME_US * 1000) / `SSC_CLK_PERIOD_NS)
`define SSC_GATE_CYCLES      2'h2
`define SSC_LP_MODE_LIGHT    2'h1
`define SSC_LP_MODE_DEEP     2'h2
`endif

// [rtl/ssc_pkg.sv]
package ssc_pkg;
    typedef enum logic [1:0] {SW_IDLE, SW_GATE, SW_SWAP, SW_UNGATE} ssc_sw_e;

    typedef struct packed {
        ssc_sw_e    st;
        logic [1:0] cnt;
        logic       tgt;
        logic       cur;
        logic       gate;
        logic       busy;
    } ssc_sw_s;

    typedef struct packed {
        logic        slow_sel;
        logic        osc_tgt;
        logic [2:0]  tick;
        logic        pd;
        logic        pd_pend;
        logic        pd_pend_val;
        logic        caldis;
        logic        caldis_eff;
        logic        cal_busy;
        logic [14:0] cal_cnt;
        logic        slow_in;
        logic        mac_strobe;
        logic        lp_grant;
        logic        xtal_pwr;
        logic        hfrc_pwr;
        logic        xtal_stb;
        logic        hfrc_stb;
        logic        hfrc_cal;
        logic        slow_xtal_en;
        logic        slow_rc_en;
        logic [7:0]  rdata;
    } ssc_ctl_s;
endpackage : ssc_pkg

// [rtl/ssc_clk_switch.sv]
`include "ssc_defines.svh"

module ssc_clk_switch (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Requested source and readiness
    input  wire logic target_sel,
    input  wire logic xtal_ok,
    input  wire logic hfrc_ok,
    // Applied source, gate enable and busy
    output logic      cur_sel,
    output logic      clk_gate_en,
    output logic      busy
);
    ssc_pkg::ssc_sw_s q;
    ssc_pkg::ssc_sw_s d;
    logic             tgt_ok;

    assign tgt_ok = (target_sel == `SSC_SRC_XTAL) ? xtal_ok : hfrc_ok;

    // ==============================================================
    // Switch sequencer
    always_comb begin
        d = q;
        case (q.st)
            ssc_pkg::SW_IDLE: begin
                // Hold off until the new source is stable
                if (target_sel != q.cur && tgt_ok) begin
                    d.tgt  = target_sel;
                    d.gate = 1'b0;
                    d.cnt  = 2'h0;
                    d.busy = 1'b1;
                    d.st   = ssc_pkg::SW_GATE;
                end
            end
            ssc_pkg::SW_GATE: begin
                // Let the old clock settle low before the swap
                d.cnt = q.cnt + 2'h1;
                if (q.cnt == `SSC_GATE_CYCLES - 2'h1) begin
                    d.st = ssc_pkg::SW_SWAP;
                end
            end
            ssc_pkg::SW_SWAP: begin
                d.cur = q.tgt;
                d.cnt = 2'h0;
                d.st  = ssc_pkg::SW_UNGATE;
            end
            ssc_pkg::SW_UNGATE: begin
                d.cnt = q.cnt + 2'h1;
                if (q.cnt == `SSC_GATE_CYCLES - 2'h1) begin
                    d.gate = 1'b1;
                    d.busy = 1'b0;
                    d.st   = ssc_pkg::SW_IDLE;
                end
            end
            default: begin
                d.st = ssc_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q.st   <= ssc_pkg::SW_IDLE;
            q.cnt  <= 2'h0;
            q.tgt  <= `SSC_SRC_RC;
            q.cur  <= `SSC_SRC_RC;
            q.gate <= 1'b1;
            q.busy <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign cur_sel     = q.cur;
    assign clk_gate_en = q.gate;
    assign busy        = q.busy;
endmodule : ssc_clk_switch

// [dv/ssc_clock_ctrl_asserts.sv]
module ssc_clock_ctrl_chk #(
    parameter logic [14:0] SLOW_CAL_CYCLES = 15'h0008
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Oscillator side
    input wire logic unused_source_powerdown,
    input wire logic xtal_stable_flag,
    input wire logic xtal_pwr_en,
    input wire logic hfrc_pwr_en,
    input wire logic hfrc_cal_en,
    input wire logic slow_xtal_en,
    input wire logic slow_rc_en,
    input wire logic slow_rc_cal_active,
    // System clock mux
    input wire logic sys_clk_sel,
    input wire logic sys_clk_gate_en,
    input wire logic sys_clk_speed_flag,
    // Slow clock and power mode
    input wire logic slow_clk_in,
    input wire logic mac_sleep_strobe,
    input wire logic lp_grant
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // ==========
    // Helper: length of the current calibration run
    int run_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_q <= 0;
        end else begin
            run_q <= slow_rc_cal_active ? run_q + 1 : 0;
        end
    end

    sequence swap_s;
        ##[1:3] $changed(sys_clk_sel) ##[1:3] sys_clk_gate_en;
    endsequence
    sequence rc_held_s;
        sys_clk_sel [*2];
    endsequence

    // ==========
    // Properties
    speed_mirror_a: assert property (sys_clk_speed_flag == sys_clk_sel)
        else $error("speed flag differs from source");
    slow_excl_a: assert property (slow_xtal_en != slow_rc_en)
        else $error("slow sources not exclusive");
    swap_gated_a: assert property ($changed(sys_clk_sel) |-> !sys_clk_gate_en)
        else $error("source changed with clock ungated");
    gate_window_a: assert property ($fell(sys_clk_gate_en) |-> swap_s)
        else $error("gate window malformed");
    xtal_ready_a: assert property ($fell(sys_clk_sel) |-> xtal_stable_flag)
        else $error("crystal taken before stable");
    rc_no_cal_a: assert property (rc_held_s |-> !hfrc_cal_en)
        else $error("fast RC calibrated while it runs system");
    both_run_a: assert property (!unused_source_powerdown [*3] |-> xtal_pwr_en && hfrc_pwr_en)
        else $error("source off with power-down clear");
    grant_idle_a: assert property (lp_grant |-> !slow_rc_cal_active)
        else $error("grant during calibration");
    cal_whole_a: assert property ($fell(slow_rc_cal_active) |->
        run_q == SLOW_CAL_CYCLES)
        else $error("calibration cut short");
    strobe_slow_a: assert property ($rose(slow_clk_in) |-> ##[1:4] mac_sleep_strobe)
        else $error("no strobe after slow edge");
endmodule : ssc_clock_ctrl_chk

bind ssc_clock_ctrl ssc_clock_ctrl_chk #(.SLOW_CAL_CYCLES(SLOW_CAL_CYCLES)) i_chk (
    .clock, .nrst, .unused_source_powerdown, .xtal_stable_flag, .xtal_pwr_en,
    .hfrc_pwr_en, .hfrc_cal_en, .slow_xtal_en, .slow_rc_en, .slow_rc_cal_active,
    .sys_clk_sel, .sys_clk_gate_en, .sys_clk_speed_flag, .slow_clk_in,
    .mac_sleep_strobe, .lp_grant
);

// [dv/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clock = 1'b0, nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic       sfr_we = 1'b0, pd_wr_en = 1'b0, pd_wr_val = 1'b0;
    logic       caldis_wr_en = 1'b0, caldis_wr_val = 1'b0;
    logic       xtal_ready = 1'b0, hfrc_ready = 1'b1, slow_clk_in = 1'b0;
    logic       lp_req = 1'b0, deep_wake = 1'b0;
    logic [1:0] lp_mode = 2'h1;
    logic [3:0] sdiv = 4'h0;
    logic       pd, caldis, xstb, xpwr, hpwr, hcal, sxen, sren, scal, sel, spd, grant;
    logic       hstb, gate, strobe;
    int         mismatches = 0, n_compared = 0, cycles = 0;

    always #50 clock = ~clock;

    ssc_clock_ctrl #(.SLOW_CAL_CYCLES(15'h0008)) i_dut (
        .clock, .nrst, .sfr_addr, .sfr_we, .sfr_wdata, .sfr_rdata,
        .pd_wr_en, .pd_wr_val, .caldis_wr_en, .caldis_wr_val,
        .unused_source_powerdown(pd), .slow_rc_cal_disable(caldis),
        .xtal_stable_flag(xstb), .hfrc_stable_flag(hstb), .xtal_ready, .hfrc_ready,
        .xtal_pwr_en(xpwr), .hfrc_pwr_en(hpwr), .hfrc_cal_en(hcal),
        .slow_xtal_en(sxen), .slow_rc_en(sren), .slow_rc_cal_active(scal),
        .sys_clk_sel(sel), .sys_clk_gate_en(gate), .sys_clk_speed_flag(spd),
        .slow_clk_in, .mac_sleep_strobe(strobe), .lp_req, .lp_mode, .deep_wake,
        .lp_grant(grant)
    );

    // ==========
    // Slow clock and watchdog on the run length
    always @(posedge clock) begin
        sdiv <= sdiv + 4'h1;
        slow_clk_in <= sdiv[3];
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end

    // ==========
    // Access tasks
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_we <= 1'b1;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfr_addr <= a;
        cyc(2);
        check("sfr_rdata", sfr_rdata, exp);
    endtask : rd

    task automatic pd_w(input logic v);
        @(posedge clock);
        pd_wr_en <= 1'b1;
        pd_wr_val <= v;
        @(posedge clock);
        pd_wr_en <= 1'b0;
        #1;
    endtask : pd_w

    // Bounded wait; a miss shows up in the compare
    task automatic waitv(input string nm, ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) begin
            cyc(1);
        end
        check(nm, s, v);
    endtask : waitv

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // ==========
    // Main sequence
    initial begin
        cyc(2);
        nrst <= 1'b1;
        rd(8'hC6, 8'hC9);
        check("pd", pd, 1);
        check("sren", {sxen, sren}, 2'b01);
        check("xpwr", {xpwr, hpwr, caldis}, 3'b010);
        check("hstb", hstb, 1);
        check("gate", gate, 1);
        waitv("strobe", strobe, 1, 20);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rd(8'hC6, 8'hC9);
        wr(8'hC6, 8'h89);
        cyc(6);
        check("xpwr", xpwr, 1);
        check("sel_wait", {sel, spd}, 2'b11);
        // Withdraw the early request, then power the crystal the legal way
        wr(8'hC6, 8'hC9);
        pd_w(0);
        cyc(2);
        check("both_pwr", {xpwr, hpwr}, 2'b11);
        @(posedge clock);
        xtal_ready <= 1'b1;
        waitv("xstb", xstb, 1, 10);
        cyc(640);
        wr(8'hC6, 8'h89);
        waitv("sel", sel, 0, 20);
        check("gate_swap", gate, 0);
        check("radio_ok", {sel, xstb}, 2'b01);
        cyc(3);
        check("spd", spd, 0);
        check("hpwr", hpwr, 1);
        rd(8'hC6, 8'h88);
        waitv("scal", scal, 1, 20);
        pd_w(1);
        waitv("pd_set", pd, 1, 30);
        cyc(2);
        check("hpwr_off", hpwr, 0);
        pd_w(0);
        check("pd_held", pd, 1);
        waitv("pd_clr", pd, 0, 30);
        waitv("hcal", hcal, 1, 40);
        @(posedge clock);
        lp_req <= 1'b1;
        waitv("grant", grant, 1, 30);
        check("scal_lp", scal, 0);
        @(posedge clock);
        lp_req <= 1'b0;
        waitv("grant_off", grant, 0, 5);
        @(posedge clock);
        caldis_wr_en <= 1'b1;
        caldis_wr_val <= 1'b1;
        @(posedge clock);
        caldis_wr_en <= 1'b0;
        cyc(12);
        waitv("scal_on", scal, 1, 12);
        wr(8'hC6, 8'hC9);
        waitv("sel_rc", sel, 1, 20);
        cyc(12);
        check("scal_off", scal, 0);
        check("caldis", caldis, 1);
        wr(8'hC6, 8'h59);
        cyc(2);
        check("slow_sel", {sxen, sren}, 2'b10);
        rd(8'hC6, 8'h59);
        @(posedge clock);
        deep_wake <= 1'b1;
        @(posedge clock);
        deep_wake <= 1'b0;
        cyc(2);
        rd(8'hC6, 8'hD9);
        check("caldis_wake", caldis, 0);
        check("pd_kept", pd, 0);
        complete_run();
    end
endmodule : testbench
